// ===== ccsk_top.sv
// Cache setup register, unlock key and zero-fill engines for two caches.
// Assumes an APB master on the same clock; index 0 is instruction, 1 is data.
`timescale 1ns/100ps
`default_nettype none

module ccsk_top #(
  parameter int LINES = 256
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Register bus
  input  wire ccsk_pkg::ccsk_apb_req_s      apb_req,
  output var  ccsk_pkg::ccsk_apb_rsp_s      apb_rsp,
  // Cache controls
  output var  ccsk_pkg::ccsk_cache_ctl_s [1:0] cache_ctl
);
  import ccsk_pkg::*;

  localparam logic [CCSK_INIT_AW-1:0] LAST = CCSK_INIT_AW'(LINES - 1);

  // ****************************************
  // Bus decode
  // ****************************************
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] setup_r;
  logic [31:0] setup_nxt;
  logic        key_valid_r;
  logic        key_valid_nxt;
  logic [CCSK_NCACHE-1:0] start;
  logic [CCSK_NCACHE-1:0] busy;
  ccsk_cache_ctl_s [1:0]  ctl_nxt;

  wire access    = apb_req.psel & apb_req.penable;
  wire answer    = access & ~pready_r;
  wire commit    = access & pready_r;
  wire hit_stat  = apb_req.paddr == CCSK_STAT_ADDR;
  wire hit_setup = apb_req.paddr == CCSK_SETUP_ADDR;
  wire hit_key   = apb_req.paddr == CCSK_KEY_ADDR;
  wire mapped    = hit_stat | hit_setup | hit_key;
  wire setup_wr  = commit & apb_req.pwrite & hit_setup;
  wire key_wr    = commit & apb_req.pwrite & hit_key;
  wire key_match = apb_req.pwdata == CCSK_KEY_VALUE;
  wire setup_ok  = setup_wr & key_valid_r;

  // ****************************************
  // Status view
  // ****************************************
  logic [31:0] status;
  always_comb begin
    status = '0;
    for (int c = 0; c < CCSK_NCACHE; c++) begin
      status[c*CCSK_DATA_BASE+CCSK_OFS_LOCK] = setup_r[c*CCSK_DATA_BASE+CCSK_OFS_LOCK];
      status[c*CCSK_DATA_BASE+CCSK_OFS_EN]   = setup_r[c*CCSK_DATA_BASE+CCSK_OFS_EN]
                                               & ~busy[c];
      status[c*CCSK_DATA_BASE+CCSK_OFS_INIT] = busy[c];
    end
  end

  wire [31:0] read_mux = hit_stat  ? status  :
                         hit_setup ? setup_r :
                         32'h00000000;

  // ****************************************
  // APB answer, one wait state
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= answer;
      pslverr_r <= answer & ~mapped;
      prdata_r  <= (answer & ~apb_req.pwrite) ? read_mux : 32'h00000000;
    end
  end

  assign apb_rsp.pready  = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign apb_rsp.prdata  = prdata_r;

  // ****************************************
  // Unlock key
  // ****************************************
  always_comb begin
    key_valid_nxt = key_valid_r;
    if (setup_wr) begin
      key_valid_nxt = 1'b0;
    end else if (key_wr) begin
      key_valid_nxt = key_match;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      key_valid_r <= 1'b0;
    end else begin
      key_valid_r <= key_valid_nxt;
    end
  end

  // ****************************************
  // Setup register
  // ****************************************
  always_comb begin
    setup_nxt = setup_r;
    if (setup_ok) begin
      setup_nxt = apb_req.pwdata & CCSK_SETUP_MASK;
    end
    for (int c = 0; c < CCSK_NCACHE; c++) begin
      if (setup_ok && apb_req.pwdata[c*CCSK_DATA_BASE+CCSK_OFS_INIT]) begin
        setup_nxt[c*CCSK_DATA_BASE+CCSK_OFS_EN]   = 1'b0;
        setup_nxt[c*CCSK_DATA_BASE+CCSK_OFS_LOCK] = 1'b0;
      end else if (start[c]) begin
        setup_nxt[c*CCSK_DATA_BASE+CCSK_OFS_INIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      setup_r <= CCSK_SETUP_RESET;
    end else begin
      setup_r <= setup_nxt;
    end
  end

  // ****************************************
  // Per-cache fill engine and controls
  // ****************************************
  for (genvar g = 0; g < CCSK_NCACHE; g++) begin : g_cache
    localparam int B = g * CCSK_DATA_BASE;
    ccsk_init_state_e        st_r;
    ccsk_init_state_e        st_nxt;
    logic [CCSK_INIT_AW-1:0] cnt_r;
    logic [CCSK_INIT_AW-1:0] cnt_nxt;

    assign start[g] = (st_r == CCSK_IDLE) & setup_r[B+CCSK_OFS_INIT];
    assign busy[g]  = st_r == CCSK_FILL;

    always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
        CCSK_IDLE: begin
          if (start[g]) begin
            st_nxt  = CCSK_FILL;
            cnt_nxt = '0;
          end
        end
        CCSK_FILL: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == LAST) begin
            st_nxt  = CCSK_IDLE;
            cnt_nxt = '0;
          end
        end
        default: begin
          st_nxt  = CCSK_IDLE;
          cnt_nxt = '0;
        end
      endcase
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        st_r  <= CCSK_IDLE;
        cnt_r <= '0;
      end else begin
        st_r  <= st_nxt;
        cnt_r <= cnt_nxt;
      end
    end

    // Zero-fill write strobe lines up with the address it names
    assign ctl_nxt[g].serve     = setup_nxt[B+CCSK_OFS_EN] & (st_nxt == CCSK_IDLE)
                                  & ~setup_nxt[B+CCSK_OFS_INIT];
    assign ctl_nxt[g].lock      = setup_nxt[B+CCSK_OFS_LOCK];
    assign ctl_nxt[g].wr_bypass = setup_nxt[B+CCSK_OFS_WRBUF];
    assign ctl_nxt[g].rd_bypass = (g == 0) ? setup_nxt[CCSK_OFS_RDBUF] : 1'b0;
    assign ctl_nxt[g].init_busy = st_nxt == CCSK_FILL;
    assign ctl_nxt[g].init_we   = st_nxt == CCSK_FILL;
    assign ctl_nxt[g].init_addr = cnt_nxt;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cache_ctl <= '0;
      cache_ctl[0].serve <= CCSK_SETUP_RESET[CCSK_OFS_EN];
    end else begin
      cache_ctl <= ctl_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_key_reads_zero: assert property (
    answer && !apb_req.pwrite && hit_key |=> apb_rsp.prdata == 32'h00000000
  ) else $error("key register read returned nonzero");

  chk_key_unlock: assert property (
    key_wr && key_match |=> key_valid_r
  ) else $error("correct key did not unlock");

  chk_key_cleared: assert property (
    setup_wr |=> !key_valid_r
  ) else $error("key survived a setup write");

  chk_setup_locked: assert property (
    setup_wr && !key_valid_r && start == '0 |=> setup_r == $past(setup_r)
  ) else $error("setup changed without key");

  chk_reserved_zero: assert property (
    (setup_r & ~CCSK_SETUP_MASK) == 32'h00000000
  ) else $error("reserved setup bit set");

  chk_data_cache_init_clears: assert property (
    setup_ok && apb_req.pwdata[CCSK_DATA_BASE+CCSK_OFS_INIT]
    |=> !setup_r[CCSK_DATA_BASE+CCSK_OFS_EN] && !setup_r[CCSK_DATA_BASE+CCSK_OFS_LOCK]
  ) else $error("data init left enable or lock set");

  chk_instr_cache_init_clears: assert property (
    setup_ok && apb_req.pwdata[CCSK_OFS_INIT]
    |=> !setup_r[CCSK_OFS_EN] && !setup_r[CCSK_OFS_LOCK]
  ) else $error("instruction init left enable or lock set");

  chk_init_starts: assert property (
    start[0] && !setup_wr |=> busy[0] && !setup_r[CCSK_OFS_INIT] && status[CCSK_OFS_INIT]
  ) else $error("instruction init did not start and self-clear");

  chk_data_cache_init_starts: assert property (
    start[1] && !setup_wr |=> busy[1] && !setup_r[CCSK_DATA_BASE+CCSK_OFS_INIT]
  ) else $error("data init did not start and self-clear");

  chk_busy_no_serve: assert property (
    busy[1] |-> !cache_ctl[1].serve && cache_ctl[1].init_we
  ) else $error("data cache served during fill");

  chk_serve_follows: assert property (
    setup_r[CCSK_DATA_BASE+CCSK_OFS_EN] && !busy[1] && !start[1] && !setup_wr
    |=> cache_ctl[1].serve
  ) else $error("enabled data cache not serving");

  chk_lock_out: assert property (
    setup_r[CCSK_DATA_BASE+CCSK_OFS_LOCK] ##1 !$past(setup_wr) |-> cache_ctl[1].lock
  ) else $error("data lock not driven");

  chk_instr_cache_lock_out: assert property (
    $rose(setup_r[CCSK_OFS_LOCK]) |-> cache_ctl[0].lock
  ) else $error("instruction lock not driven");

  chk_bypass_out: assert property (
    $rose(setup_r[CCSK_DATA_BASE+CCSK_OFS_WRBUF]) |-> cache_ctl[1].wr_bypass
  ) else $error("write buffer bypass not driven");

  chk_rdbuf_out: assert property (
    $rose(setup_r[CCSK_OFS_RDBUF]) |-> cache_ctl[0].rd_bypass
  ) else $error("read buffer bypass not driven");

endmodule // ccsk_top

`default_nettype wire

// ===== ccsk_pkg.sv
// Constants, types and bus carriers for the flash cache setup and key control.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
//
// Behaviour
// - Write-buffer bypass bits 19 and 3 skip the write buffer hit check.
// - Read-buffer bypass bit 4 skips the read buffer hit check.
// - Data lock bit 18 freezes data cache contents; misses replace nothing.
// - Data enable bit 17 routes accesses to data cache, else to flash.
// - Data init bit 16 zero-fills the data cache and self-clears at start.
// - Setting data init clears data lock and data enable.
// - Instruction lock bit 2 freezes instruction cache; misses replace nothing.
// - Instruction enable bit 1 resets to one; set serves, clear goes to flash.
// - Instruction init bit 0 zero-fills instruction cache and self-clears at start.
// - Setting instruction init clears instruction lock and instruction enable.
// - Protected writes are allowed only after key value 0xf123f456 is written.
// - The key register is write-only and reads back as zero.
// - Any setup register write clears the stored key.
// - Status init flag is high during fill; that cache stays disabled meanwhile.

package ccsk_pkg;

  // ****************************************
  // Register map and values
  // ****************************************
  localparam logic [31:0] CCSK_STAT_ADDR   = 32'h400180c0;
  localparam logic [31:0] CCSK_SETUP_ADDR  = 32'h400180c4;
  localparam logic [31:0] CCSK_KEY_ADDR    = 32'h400180c8;
  localparam logic [31:0] CCSK_KEY_VALUE   = 32'hf123f456;
  localparam logic [31:0] CCSK_SETUP_RESET = 32'h00000002;
  localparam logic [31:0] CCSK_KEY_RESET   = 32'h00000000;
  localparam logic [31:0] CCSK_SETUP_MASK  = 32'h000f001f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CCSK_DATA_BASE = 16;
  localparam int CCSK_OFS_INIT  = 0;
  localparam int CCSK_OFS_EN    = 1;
  localparam int CCSK_OFS_LOCK  = 2;
  localparam int CCSK_OFS_WRBUF = 3;
  localparam int CCSK_OFS_RDBUF = 4;
  localparam int CCSK_NCACHE    = 2;
  localparam int CCSK_INIT_AW   = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    CCSK_IDLE = 1'b0,
    CCSK_FILL = 1'b1
  } ccsk_init_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ccsk_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccsk_apb_rsp_s;

  typedef struct packed {
    logic                    serve;
    logic                    lock;
    logic                    wr_bypass;
    logic                    rd_bypass;
    logic                    init_busy;
    logic                    init_we;
    logic [CCSK_INIT_AW-1:0] init_addr;
  } ccsk_cache_ctl_s;

endpackage

// ===== ccsk_cache_model.sv
// Far-side model of one cache memory that records its zero-fill writes.
// Assumes the control carrier of one cache from the setup block.
`timescale 1ns/100ps
`default_nettype none

module ccsk_cache_model (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Cache controls
  input  wire ccsk_pkg::ccsk_cache_ctl_s ctl,
  // Observations
  output var  logic [8:0]                fill_lines,
  output var  logic                      fault
);
  import ccsk_pkg::*;

  always_ff @(posedge clock) begin
    if (rst) begin
      fill_lines <= 9'h000;
      fault      <= 1'b0;
    end else begin
      if (ctl.init_we === 1'b1) begin
        fill_lines <= fill_lines + 9'h001;
        if (ctl.init_addr !== fill_lines[7:0]) fault <= 1'b1;
      end
      if (ctl.serve === 1'b1 && ctl.init_busy === 1'b1) fault <= 1'b1;
    end
  end
endmodule // ccsk_cache_model

`default_nettype wire

// ===== cache_setup_key_control_test.sv
// Self-checking bench for the cache setup and key block over APB.
// Assumes the design package and the cache model file are compiled first.
`timescale 1ns/100ps
`default_nettype none

module cache_setup_key_control_test;
  import ccsk_pkg::*;
  localparam int LN = 4;
  logic            clock = 1'b0;
  logic            rst   = 1'b1;
  ccsk_apb_req_s   req   = '0;
  ccsk_apb_rsp_s   rsp;
  ccsk_cache_ctl_s [1:0] ctl;
  logic [8:0]      fill [2];
  logic            fault [2];
  int              n_mismatch = 0;
  int              samples_checked = 0;
  logic [31:0]     q;
  logic            e;

  always #25 clock = ~clock;

  ccsk_top #(.LINES(LN)) dut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .cache_ctl(ctl));
  ccsk_cache_model m0 (.clock(clock), .rst(rst), .ctl(ctl[0]), .fill_lines(fill[0]),
    .fault(fault[0]));
  ccsk_cache_model m1 (.clock(clock), .rst(rst), .ctl(ctl[1]), .fill_lines(fill[1]),
    .fault(fault[1]));

  // ****************************************
  // Checks and bus cycles
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    tally_and_finish;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({ctl[0].serve, ctl[1].serve}, 32'h00000002);
    rd(CCSK_SETUP_ADDR, 32'h00000002);
    rd(CCSK_STAT_ADDR, 32'h00000002);
    rd(CCSK_KEY_ADDR, 32'h00000000);
    $display("reset test done");
    xfer(1'b1, CCSK_KEY_ADDR, 32'h12345678);
    xfer(1'b1, CCSK_SETUP_ADDR, 32'h000a0000);
    rd(CCSK_SETUP_ADDR, 32'h00000002);
    $display("bad key test done");
    xfer(1'b1, CCSK_KEY_ADDR, CCSK_KEY_VALUE);
    xfer(1'b1, CCSK_SETUP_ADDR, 32'hfffefffe);
    @(negedge clock);
    chk({ctl[1].serve, ctl[1].lock, ctl[1].wr_bypass, ctl[1].rd_bypass}, 32'he);
    chk({ctl[0].serve, ctl[0].lock, ctl[0].wr_bypass, ctl[0].rd_bypass}, 32'hf);
    @(posedge clock);
    rd(CCSK_SETUP_ADDR, 32'h000e001e);
    rd(CCSK_STAT_ADDR, 32'h00060006);
    rd(CCSK_KEY_ADDR, 32'h00000000);
    xfer(1'b1, CCSK_SETUP_ADDR, 32'h00000000);
    rd(CCSK_SETUP_ADDR, 32'h000e001e);
    $display("setup test done");
    xfer(1'b1, CCSK_KEY_ADDR, CCSK_KEY_VALUE);
    rd(CCSK_KEY_ADDR, 32'h00000000);
    xfer(1'b1, CCSK_SETUP_ADDR, 32'h00070007);
    @(negedge clock);
    chk({ctl[0].init_busy, ctl[1].init_busy, ctl[0].serve, ctl[1].serve}, 32'hc);
    while (ctl[0].init_busy !== 1'b0 || ctl[1].init_busy !== 1'b0) begin
      @(negedge clock);
    end
    chk({23'h0, fill[1]}, LN);
    chk({23'h0, fill[0]}, LN);
    chk({fault[0], fault[1], ctl[0].serve, ctl[1].serve}, 32'h0);
    @(posedge clock);
    rd(CCSK_SETUP_ADDR, 32'h00000000);
    rd(CCSK_STAT_ADDR, 32'h00000000);
    $display("init test done");
    xfer(1'b0, 32'h400180cc, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    chk(q, 32'h00000000);
    $display("unmapped test done");
    xfer(1'b1, CCSK_KEY_ADDR, CCSK_KEY_VALUE);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({ctl[0].serve, ctl[1].serve}, 32'h00000002);
    xfer(1'b1, CCSK_SETUP_ADDR, 32'h00080000);
    rd(CCSK_SETUP_ADDR, 32'h00000002);
    $display("reset rerun test done");
    tally_and_finish;
  end
endmodule // cache_setup_key_control_test

`default_nettype wire
